// >>> src/motion_cmd_regs.svh
// Purpose: Constants for the motion command handler
// Assumes: 40 MHz clk, one motor axis
// Notes:   Opcodes, reply codes and register offsets
// Functional notes
// - Extension opcodes 64-71 reply status 100
// - Reached request gives two replies
// - Reached request only from host, direct
// - Type 0 arms once, type 1 always
// - Immediate reply echoes 8Ah with mask
// - Additional reply uses status 80h
// - Control commands only from host, direct
// - Opcode 128 stops program
// - Opcode 129 runs from pc or address
// - Opcode 130 executes one instruction
// - Opcode 131 stops and clears engine state
// - Opcode 132 enters download at address
// - Opcode 133 leaves download
// - Opcode 134 reads program memory word
// - Opcode 135 reports status by type
// - Opcode 136 returns firmware version
// - Opcode 137 with 1234 restores, no reply
// - Opcode 255 with 1234 restarts module
`ifndef MOTION_CMD_REGS_SVH
`define MOTION_CMD_REGS_SVH
`define OP_USER_LO    8'h40
`define OP_USER_HI    8'h47
`define OP_MOVE       8'h04
`define OP_STOP       8'h80
`define OP_RUN        8'h81
`define OP_STEP       8'h82
`define OP_RESET      8'h83
`define OP_DL_ENTER   8'h84
`define OP_DL_EXIT    8'h85
`define OP_MEM_READ   8'h86
`define OP_STATUS     8'h87
`define OP_VERSION    8'h88
`define OP_FACTORY    8'h89
`define OP_REACHED    8'h8a
`define OP_SW_RESET   8'hff
`define MAGIC_KEY     32'h000004d2
`define ST_OK         8'h64
`define ST_REACHED    8'h80
`define ST_BAD_CMD    8'h02
`define ST_BAD_VALUE  8'h04
`define REG_CFG       4'h0
`define REG_STAT      4'h1
`define CFG_MOD_RST   8'h01
`define CFG_HOST_RST  8'h02
`endif

// >>> src/motion_cmd_pkg.sv
// Purpose: Types for the motion command handler
// Assumes: Constants live in motion_cmd_regs.svh
// Notes:   Frames travel as packed structs
package motion_cmd_pkg;
    typedef struct packed {
        logic        from_prog; // Issued by stored program
        logic [7:0]  op;
        logic [7:0]  typ;
        logic [7:0]  bank;
        logic [31:0] value;
    } cmd_s;
    typedef struct packed {
        logic [7:0]  host_adr;
        logic [7:0]  mod_adr;
        logic [7:0]  status;
        logic [7:0]  op;
        logic [31:0] value;
        logic [7:0]  csum;
    } rsp_s;
    typedef enum logic [2:0] {
        PS_STOP = 3'b001,
        PS_RUN  = 3'b010,
        PS_STEP = 3'b100
    } prog_e;
endpackage

// >>> src/motion_cmd_handler.sv
// Purpose: Control-command, extension and reached-event handling
// Assumes: One frame per cmd_valid pulse, program engine outside
// Notes:   Non-control commands go to the engine, the extension logic or into memory
`timescale 1ns/100ps
`include "motion_cmd_regs.svh"
module motion_cmd_handler #(
    parameter int          MEM_AW     = 4,            // Program memory address bits
    parameter logic [31:0] FW_VERSION = 32'h00010001, // Arbitrary value
    parameter logic [31:0] FW_STRING  = 32'h56313031  // Arbitrary value
) (
    input  wire logic                  clk,         // 40 MHz clock
    input  wire logic                  rst,         // Async reset, high
    input  wire logic                  cmd_valid,   // Frame strobe
    input  wire motion_cmd_pkg::cmd_s  cmd,         // Decoded frame
    input  wire logic                  reached,     // Target reached pulse
    input  wire logic                  instr_done,  // Engine finished one instr
    input  wire logic                  wait_flag,   // Engine wait flag
    input  wire logic [15:0]           pc,          // Engine program counter
    input  wire logic [31:0]           accu,        // Engine accumulator
    input  wire logic [31:0]           xreg,        // Engine index register
    input  wire logic [31:0]           user_result, // Extension result
    input  wire logic [3:0]            reg_addr,    // Register index
    input  wire logic [31:0]           reg_wdata,   // Write data
    input  wire logic                  reg_wr,      // Write strobe
    input  wire logic                  reg_rd,      // Read strobe
    output logic [31:0]                reg_rdata,   // Read data, next cycle
    output logic                       rsp_valid,   // Reply strobe
    output motion_cmd_pkg::rsp_s       rsp,         // Reply frame
    output logic                       exec_valid,  // Forwarded command strobe
    output motion_cmd_pkg::cmd_s       exec_cmd,    // Forwarded command
    output logic                       user_valid,  // Extension opcode strobe
    output logic                       prog_run,    // Engine run level
    output logic                       prog_step,   // One-instruction pulse
    output logic                       prog_clear,  // Clear pc, sp, acc, x, flags
    output logic                       pc_load,     // Load pc from pc_start
    output logic [15:0]                pc_start,    // Start address
    output logic                       factory,     // Restore defaults pulse
    output logic                       sw_reset     // Module restart pulse
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0]  mod_adr_r;
    logic [7:0]  host_adr_r;
    logic [31:0] reg_rdata_r;
    motion_cmd_pkg::prog_e ps_r;
    logic        dl_r;
    logic [MEM_AW-1:0] dl_ptr_r;
    logic [55:0] mem_r [2**MEM_AW];
    logic        armed_r;
    logic        once_r;
    logic        pend_r;
    logic [7:0]  mask_r;
    logic        rsp_valid_r;
    motion_cmd_pkg::rsp_s rsp_r;
    logic        exec_valid_r;
    motion_cmd_pkg::cmd_s exec_cmd_r;
    logic        user_valid_r;
    logic        prog_step_r;
    logic        prog_clear_r;
    logic        pc_load_r;
    logic [15:0] pc_start_r;
    logic        factory_r;
    logic        sw_reset_r;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the incoming frame
    logic is_ctrl;
    logic is_user;
    logic host;
    logic key_ok;
    logic reply_now;
    logic [MEM_AW-1:0] rd_idx;
    logic [55:0] rd_word;

    assign host    = cmd_valid && !cmd.from_prog;
    assign key_ok  = cmd.value == `MAGIC_KEY;
    assign is_user = cmd.op >= `OP_USER_LO && cmd.op <= `OP_USER_HI;
    assign rd_idx  = cmd.value[MEM_AW-1:0];
    assign rd_word = mem_r[rd_idx];

    // Control group is 128..138 plus 255
    always_comb begin
        is_ctrl = (cmd.op >= `OP_STOP && cmd.op <= `OP_REACHED)
                  || cmd.op == `OP_SW_RESET;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply content for the command in this cycle
    logic [7:0]  st_nxt;
    logic [31:0] val_nxt;
    logic [7:0]  op_nxt;

    always_comb begin
        st_nxt    = `ST_OK;
        op_nxt    = cmd.op;
        val_nxt   = 32'h0;
        reply_now = 1'b0;
        if (cmd_valid && is_ctrl && cmd.from_prog) begin
            reply_now = 1'b0; // Program-issued control is dropped
        end else if (host && is_ctrl) begin
            reply_now = 1'b1;
            unique case (cmd.op)
                `OP_MEM_READ: begin
                    st_nxt  = rd_word[55:48]; // Stored opcode
                    val_nxt = rd_word[31:0];
                end
                `OP_STATUS: begin
                    unique case (cmd.typ)
                        8'h00: val_nxt = {4'h0, wait_flag, ps_r, 7'h0, dl_r,
                                          16'(dl_ptr_r)};
                        8'h01: val_nxt = {4'h0, wait_flag, ps_r, 7'h0, dl_r,
                                          pc};
                        8'h02: val_nxt = accu;
                        8'h03: val_nxt = xreg;
                        default: st_nxt = `ST_BAD_VALUE;
                    endcase
                end
                `OP_VERSION: begin
                    val_nxt = cmd.typ == 8'h00 ? FW_STRING : FW_VERSION;
                end
                `OP_REACHED: begin
                    val_nxt = {24'h0, cmd.value[7:0]}; // Mask echo
                end
                `OP_FACTORY: begin
                    reply_now = !key_ok; // Silent when accepted
                    st_nxt    = `ST_BAD_VALUE;
                end
                `OP_SW_RESET: begin
                    reply_now = !key_ok; // Restart swallows reply
                    st_nxt    = `ST_BAD_VALUE;
                end
                default: val_nxt = 32'h0;
            endcase
        end else if (cmd_valid && (dl_r || is_user)) begin
            reply_now = 1'b1;
            if (is_user && !dl_r) begin
                val_nxt = user_result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply sender; immediate reply wins, event reply waits for the next reached pulse
    function automatic motion_cmd_pkg::rsp_s mk(input logic [7:0] st,
                                                input logic [7:0] op,
                                                input logic [31:0] v);
        motion_cmd_pkg::rsp_s r;
        r.host_adr = host_adr_r;
        r.mod_adr  = mod_adr_r;
        r.status   = st;
        r.op       = op;
        r.value    = v;
        r.csum     = 8'(r.host_adr + r.mod_adr + st + op
                        + v[31:24] + v[23:16] + v[15:8] + v[7:0]);
        return r;
    endfunction

    logic send_evt;
    assign send_evt = pend_r && reached && !reply_now;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid_r <= 1'b0;
            rsp_r       <= '0;
        end else begin
            rsp_valid_r <= reply_now || send_evt;
            if (reply_now) begin
                rsp_r <= mk(st_nxt, op_nxt, val_nxt);
            end else if (send_evt) begin
                rsp_r <= mk(`ST_REACHED, `OP_REACHED,
                            {24'h0, mask_r});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reached-event arming
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
            once_r  <= 1'b0;
            mask_r  <= 8'h00;
        end else if (host && cmd.op == `OP_REACHED && !dl_r) begin
            armed_r <= 1'b1;
            once_r  <= cmd.typ == 8'h00;
            mask_r  <= cmd.value[7:0];
        end else if (send_evt && once_r) begin
            armed_r <= 1'b0;
        end
    end

    // A move while armed waits for reached; a held event keeps pending
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else if (cmd_valid && !dl_r && cmd.op == `OP_MOVE && armed_r) begin
            pend_r <= 1'b1;
        end else if (send_evt) begin
            pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program run state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ps_r <= motion_cmd_pkg::PS_STOP;
        end else if (host && cmd.op >= `OP_STOP && cmd.op <= `OP_RESET) begin
            // Other host frames must not swallow the end of a step
            unique case (cmd.op)
                `OP_STOP:  ps_r <= motion_cmd_pkg::PS_STOP;
                `OP_RESET: ps_r <= motion_cmd_pkg::PS_STOP;
                `OP_RUN:   ps_r <= motion_cmd_pkg::PS_RUN;
                `OP_STEP:  ps_r <= motion_cmd_pkg::PS_STEP;
                default:   ps_r <= ps_r;
            endcase
        end else if (ps_r == motion_cmd_pkg::PS_STEP && instr_done) begin
            ps_r <= motion_cmd_pkg::PS_STOP;
        end
    end

    // Engine strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_step_r  <= 1'b0;
            prog_clear_r <= 1'b0;
            pc_load_r    <= 1'b0;
            pc_start_r   <= 16'h0;
            factory_r    <= 1'b0;
            sw_reset_r   <= 1'b0;
        end else begin
            prog_step_r  <= host && cmd.op == `OP_STEP;
            prog_clear_r <= host && cmd.op == `OP_RESET;
            pc_load_r    <= host && cmd.op == `OP_RUN && cmd.typ == 8'h01;
            if (host && cmd.op == `OP_RUN) begin
                pc_start_r <= cmd.value[15:0];
            end
            factory_r    <= host && cmd.op == `OP_FACTORY && key_ok;
            sw_reset_r   <= host && cmd.op == `OP_SW_RESET && key_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Download mode and program memory
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dl_r     <= 1'b0;
            dl_ptr_r <= '0;
        end else if (host && cmd.op == `OP_DL_ENTER) begin
            dl_r     <= 1'b1;
            dl_ptr_r <= cmd.value[MEM_AW-1:0];
        end else if (host && cmd.op == `OP_DL_EXIT) begin
            dl_r <= 1'b0;
        end else if (cmd_valid && dl_r && !is_ctrl) begin
            dl_ptr_r <= dl_ptr_r + 1'b1;
        end
    end

    // Memory has no reset; it holds whatever was downloaded
    always_ff @(posedge clk) begin
        if (cmd_valid && dl_r && !is_ctrl) begin
            mem_r[dl_ptr_r] <= {cmd.op, cmd.typ, cmd.bank, cmd.value};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Forwarding to the engine and extension logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exec_valid_r <= 1'b0;
            exec_cmd_r   <= '0;
            user_valid_r <= 1'b0;
        end else begin
            exec_valid_r <= cmd_valid && !dl_r && !is_ctrl && !is_user;
            user_valid_r <= cmd_valid && !dl_r && is_user;
            if (cmd_valid) begin
                exec_cmd_r <= cmd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mod_adr_r  <= `CFG_MOD_RST;
            host_adr_r <= `CFG_HOST_RST;
        end else if (reg_wr && reg_addr == `REG_CFG) begin
            mod_adr_r  <= reg_wdata[7:0];
            host_adr_r <= reg_wdata[15:8];
        end
    end

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `REG_CFG:  reg_rdata_r <= {16'h0, host_adr_r, mod_adr_r};
                `REG_STAT: reg_rdata_r <= {8'(dl_ptr_r), 13'h0, ps_r,
                                           4'h0, pend_r, once_r, armed_r, dl_r};
                default:   reg_rdata_r <= 32'h0;
            endcase
        end else begin
            reg_rdata_r <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign reg_rdata  = reg_rdata_r;
    assign rsp_valid  = rsp_valid_r;
    assign rsp        = rsp_r;
    assign exec_valid = exec_valid_r;
    assign exec_cmd   = exec_cmd_r;
    assign user_valid = user_valid_r;
    assign prog_run   = ps_r[1]; // Run bit of the one-hot state
    assign prog_step  = prog_step_r;
    assign prog_clear = prog_clear_r;
    assign pc_load    = pc_load_r;
    assign pc_start   = pc_start_r;
    assign factory    = factory_r;
    assign sw_reset   = sw_reset_r;

endmodule

// >>> tb/motion_cmd_handler_properties.sv
// Purpose: Port-level properties of the command handler
// Assumes: Reply strobes come one cycle after the taking edge
// Notes:   Download state is tracked here from the host commands
`timescale 1ns/100ps
module motion_cmd_handler_chk (
    input wire logic                 clk,        // Module clock
    input wire logic                 rst,        // Async reset, high
    input wire logic                 cmd_valid,  // Frame strobe
    input wire motion_cmd_pkg::cmd_s cmd,        // Decoded frame
    input wire logic                 reached,    // Target reached pulse
    input wire logic                 rsp_valid,  // Reply strobe
    input wire motion_cmd_pkg::rsp_s rsp,        // Reply frame
    input wire logic                 exec_valid, // Forwarded strobe
    input wire logic                 prog_run,   // Run level
    input wire logic                 prog_clear, // Clear pulse
    input wire logic                 pc_load,    // Load pulse
    input wire logic [15:0]          pc_start,   // Start address
    input wire logic                 factory,    // Restore pulse
    input wire logic                 sw_reset    // Restart pulse
);
    logic dl_r;
    wire logic host = cmd_valid && !cmd.from_prog;
    wire logic ctl  = cmd.op inside {[8'h80:8'h8a], 8'hff};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Mirror of download mode, so stored commands can be told apart
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            dl_r <= 1'b0;
        else if (host && cmd.op == 8'h84)
            dl_r <= 1'b1;
        else if (host && cmd.op == 8'h85)
            dl_r <= 1'b0;
    end
    ////////////////////////////////
    property p_user;
        host && cmd.op inside {[8'h40:8'h47]} && !dl_r |=>
            rsp_valid && rsp.status == 8'h64 && rsp.op == $past(cmd.op);
    endproperty
    a_user: assert property (p_user) else $error("extension reply wrong");
    property p_csum;
        rsp_valid |-> rsp.csum == 8'(rsp.host_adr + rsp.mod_adr + rsp.status + rsp.op
            + rsp.value[31:24] + rsp.value[23:16] + rsp.value[15:8] + rsp.value[7:0]);
    endproperty
    a_csum: assert property (p_csum) else $error("reply checksum wrong");
    property p_evt;
        rsp_valid && rsp.status == 8'h80 |-> $past(reached) && rsp.op == 8'h8a;
    endproperty
    a_evt: assert property (p_evt) else $error("event reply out of place");
    property p_refuse;
        cmd_valid && cmd.from_prog && ctl && !reached |=>
            !rsp_valid && !prog_clear && !pc_load && !factory && !sw_reset;
    endproperty
    a_refuse: assert property (p_refuse) else $error("program control op acted");
    property p_run;
        host && cmd.op == 8'h81 && cmd.typ == 8'h01 |=>
            pc_load && prog_run && pc_start == $past(cmd.value[15:0]);
    endproperty
    a_run: assert property (p_run) else $error("run from address wrong");
    property p_stop;
        host && cmd.op == 8'h80 |=> !prog_run;
    endproperty
    a_stop: assert property (p_stop) else $error("stop left program running");
    property p_clr;
        host && cmd.op == 8'h83 |=> prog_clear && !prog_run;
    endproperty
    a_clr: assert property (p_clr) else $error("reset op did not clear");
    property p_dl;
        dl_r && host && !ctl |=> rsp_valid && rsp.value == 32'h0 && !exec_valid;
    endproperty
    a_dl: assert property (p_dl) else $error("download did not store");
    property p_fact;
        host && cmd.op == 8'h89 && cmd.value == 32'h4d2 |=> factory && !rsp_valid;
    endproperty
    a_fact: assert property (p_fact) else $error("restore replied or idle");
    // Main scenarios seen at least once
    c_evt: cover property (rsp_valid && rsp.status == 8'h80);
    c_dl: cover property (dl_r && host && !ctl);
    c_run: cover property (host && cmd.op == 8'h81);
endmodule
bind motion_cmd_handler motion_cmd_handler_chk u_chk (.*);

// >>> tb/engine_model.sv
// Purpose: Program engine and motor standing beside the handler
// Assumes: A move ends a fixed 6 cycles after it is forwarded
// Notes:   State values are arbitrary but distinct, to catch swaps
`timescale 1ns/100ps
module engine_model (
    input  wire logic                 clk,        // Module clock
    input  wire logic                 rst,        // Async reset, high
    input  wire logic                 exec_valid, // Forwarded strobe
    input  wire motion_cmd_pkg::cmd_s exec_cmd,   // Forwarded command
    input  wire logic                 prog_step,  // Step pulse
    input  wire logic                 prog_clear, // Clear pulse
    output logic                      reached,    // Target reached pulse
    output logic                      instr_done, // Instruction done pulse
    output logic                      wait_flag,  // Wait flag
    output logic [15:0]               pc,         // Program counter
    output logic [31:0]               accu,       // Accumulator
    output logic [31:0]               xreg        // Index register
);
    logic [3:0] mv_r;
    logic [1:0] st_r;
    assign wait_flag = pc[0];
    // Move and step timers; a reached pulse follows every move
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {mv_r, st_r, reached, instr_done} <= '0;
        end else begin
            reached    <= (mv_r == 4'h1);
            instr_done <= (st_r == 2'h1);
            mv_r <= (exec_valid && exec_cmd.op == 8'h04) ? 4'h5 : mv_r - 4'(mv_r != 0);
            st_r <= prog_step ? 2'h3 : st_r - 2'(st_r != 0);
        end
    end
    // Engine state: cleared on request, advanced per instruction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {pc, accu, xreg} <= {16'h0, 32'h00001234, 32'h000000a5};
        end else if (prog_clear) begin
            {pc, accu, xreg} <= '0;
        end else if (instr_done) begin
            {pc, accu, xreg} <= {pc + 16'h1, accu + 32'h3, xreg + 32'h1};
        end
    end
endmodule

// >>> tb/motion_control_command_handler_tb.sv
// Purpose: Self-checking bench of the command handler
// Assumes: Default addresses 02h host, 01h module
// Notes:   Replies are sampled in the one cycle they stand
`timescale 1ns/100ps
module motion_control_command_handler_tb;
    localparam logic [31:0] FWV = 32'h00010001; // Arbitrary value
    localparam logic [31:0] FWS = 32'h56313031; // Arbitrary value
    logic                 clk, rst, cmd_valid, reached, instr_done, wait_flag, reg_wr, reg_rd;
    logic                 rsp_valid, exec_valid, user_valid, prog_run, prog_step, prog_clear;
    logic                 pc_load, factory, sw_reset, got, gx, gu, gf, gs, gp, gc;
    logic [15:0]          pc, pc_start;
    logic [31:0]          accu, xreg, user_result, reg_wdata, reg_rdata, rd, rnd, v1, v2;
    logic [3:0]           reg_addr;
    motion_cmd_pkg::cmd_s cmd, exec_cmd;
    motion_cmd_pkg::rsp_s rsp, gr;
    int                   n_fail = 0, n_checks = 0, cyc = 0, i;
    motion_cmd_handler #(.FW_VERSION(FWV), .FW_STRING(FWS)) u_dut (.*);
    engine_model u_eng (.*);
    ////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] cs(input logic [7:0] s, o, input logic [31:0] v);
        return 8'h03 + s + o + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    endfunction
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic exp(input logic [7:0] st, o, input logic [31:0] v);
        chk(got === 1'b1 && gr === {8'h02, 8'h01, st, o, v, cs(st, o, v)}, "reply");
    endtask
    // One frame; the reply cycle is captured right after the taking edge
    task automatic send(input logic [7:0] op, ty, input logic [31:0] v, input logic fp);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= {fp, op, ty, 8'h00, v};
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        {got, gx, gu, gf, gs, gp, gc} = {rsp_valid, exec_valid, user_valid, factory,
                                         sw_reset, prog_step, prog_clear};
        gr = rsp;
    endtask
    // First reply within n cycles, for the late event replies
    task automatic wt(input int n);
        got = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (rsp_valid === 1'b1 && got === 1'b0) begin
                got = 1'b1;
                gr  = rsp;
            end
        end
    endtask
    task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'b00;
        #1;
        rd = reg_rdata;
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard, far above the roughly 190 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        rst = 1'b1;
        {cmd_valid, reg_wr, reg_rd, reg_addr, reg_wdata, user_result, cmd} = '0;
        rnd = 32'h95bf363c;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(rsp === '0 && prog_run === 1'b0 && pc_start === 16'h0, "reset");
        rg(0, 4'h0, 0);
        chk(rd[15:0] === 16'h0201, "cfg reset");
        rg(1, 4'h0, 32'h0305);
        rg(0, 4'h0, 0);
        chk(rd[15:0] === 16'h0305, "cfg write");
        rg(1, 4'h0, 32'h0201);
        rg(1, 4'h1, 32'hffffffff);
        rg(0, 4'h1, 0);
        chk(rd[10:8] === 3'b001 && rd[0] === 1'b0, "stat");
        rg(0, 4'hf, 0);
        chk(rd === 32'h0, "unmapped");
        for (i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            user_result = rnd;
            send(8'h40 + 8'(i), rnd[7:0], lfsr(rnd), 0);
            exp(8'h64, 8'h40 + 8'(i), rnd);
            chk(gu === 1'b1, "user strobe");
        end
        send(8'h8a, 1, 1, 0);
        exp(8'h64, 8'h8a, 1);
        for (i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            send(8'h04, 0, rnd, 0);
            chk(gx === 1'b1 && exec_cmd.value === rnd, "forward");
            wt(12);
            exp(8'h80, 8'h8a, 1);
        end
        send(8'h8a, 0, 1, 0);
        exp(8'h64, 8'h8a, 1);
        send(8'h04, 0, 5, 0);
        wt(12);
        exp(8'h80, 8'h8a, 1);
        send(8'h04, 0, 6, 0);
        wt(12);
        chk(got === 1'b0, "once armed twice");
        send(8'h8a, 1, 1, 1);
        chk(got === 1'b0, "program arm");
        send(8'h04, 0, 7, 0);
        wt(12);
        chk(got === 1'b0, "unarmed event");
        for (i = 0; i < 12; i++) begin
            send((i == 11) ? 8'hff : 8'h80 + 8'(i), 0, 32'h4d2, 1);
            chk(got === 1'b0 && gf === 1'b0 && gs === 1'b0, "program control");
        end
        rnd = lfsr(rnd);
        send(8'h81, 1, {16'h0, rnd[15:0]}, 0);
        chk(pc_start === rnd[15:0] && prog_run === 1'b1, "run at");
        send(8'h80, 0, 0, 0);
        chk(prog_run === 1'b0, "stop");
        send(8'h81, 0, 0, 0);
        chk(prog_run === 1'b1, "resume");
        send(8'h80, 0, 0, 0);
        send(8'h82, 0, 0, 0);
        chk(gp === 1'b1, "step");
        repeat (6) @(posedge clk);
        rg(0, 4'h1, 0);
        chk(rd[10:8] === 3'b001 && prog_run === 1'b0, "step ends");
        send(8'h87, 2, 0, 0);
        exp(8'h64, 8'h87, accu);
        send(8'h87, 3, 0, 0);
        exp(8'h64, 8'h87, xreg);
        send(8'h87, 1, 0, 0);
        chk(gr.value === {4'h0, wait_flag, 3'b001, 8'h00, pc}, "pc status");
        send(8'h87, 4, 0, 0);
        chk(got === 1'b1 && gr.status === 8'h04, "bad type");
        send(8'h83, 0, 0, 0);
        chk(gc === 1'b1 && prog_run === 1'b0, "clear");
        send(8'h88, 1, 0, 0);
        exp(8'h64, 8'h88, FWV);
        send(8'h88, 0, 0, 0);
        exp(8'h64, 8'h88, FWS);
        v1 = lfsr(rnd);
        v2 = lfsr(v1);
        send(8'h84, 0, 3, 0);
        send(8'h05, 1, v1, 0);
        exp(8'h64, 8'h05, 0);
        chk(gx === 1'b0, "stored not run");
        send(8'h06, 0, v2, 0);
        send(8'h87, 0, 0, 0);
        chk(gr.value === {4'h0, wait_flag, 3'b001, 8'h01, 16'h0005}, "dl status");
        send(8'h85, 0, 0, 0);
        send(8'h86, 0, 3, 0);
        exp(8'h05, 8'h86, v1);
        send(8'h86, 0, 4, 0);
        exp(8'h06, 8'h86, v2);
        send(8'h05, 0, v1, 0);
        chk(gx === 1'b1 && got === 1'b0, "executed again");
        send(8'h89, 0, 32'h4d2, 0);
        chk(got === 1'b0 && gf === 1'b1, "restore");
        send(8'h89, 0, 5, 0);
        chk(got === 1'b1 && gr.status === 8'h04, "restore key");
        send(8'hff, 0, 32'h4d2, 0);
        chk(gs === 1'b1, "restart");
        complete_run();
    end
endmodule
